// file: logic/bscs_consts.vh
// Constants for the boot sequencer and system clock selection block
`ifndef BSCS_CONSTS_VH
`define BSCS_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define BSCS_IDX_CLK_CFG      16'h1c1f
`define BSCS_IDX_BOOT_MODE    16'h1c34
`define BSCS_ADDR_SHIFT       2

// Clock configuration register fields
`define BSCS_CCR_SYSSEL_BIT   0
`define BSCS_CCR_PINSTAT_BIT  2

// Clock source codes driven to the clock mux
`define BSCS_CLK_BYP_OSC      2'h0
`define BSCS_CLK_BYP_EXT      2'h1
`define BSCS_CLK_PLL          2'h2

// Boot mode encodings (low four bits of the captured field)
`define BSCS_MODE_NOR         4'h0
`define BSCS_MODE_NAND        4'h1
`define BSCS_MODE_HOSTPORT    4'hc
`define BSCS_MODE_SFLASH10    4'hd
`define BSCS_MODE_SFLASH40    4'he

// Read port source codes
`define BSCS_SRC_SFLASH       2'h0
`define BSCS_SRC_ASYNC        2'h1
`define BSCS_SRC_ONCHIP       2'h2

// Chip selects
`define BSCS_CS_SFLASH        3'h0
`define BSCS_CS_FIRST_ASYNC   3'h2
`define BSCS_CS_LAST_ASYNC    3'h5

// Serial port 1 mode value for flash boot
`define BSCS_SP1_MODE_FLASH   2'h1

// Reset vector fetch address
`define BSCS_RESET_VECTOR     24'hffff00

// Host-port mailbox words in the last single-access RAM block
`define BSCS_HP_ENTRY_HI      24'h027ffa
`define BSCS_HP_SIG_A         16'h1234
`define BSCS_HP_SIG_B         16'habcd
`define BSCS_HP_WORDS         2'h3
// Dual-access RAM ends below this word address
`define BSCS_DUAL_ACCESS_RAM_END        32'h00008000

// Image address of the boot signature
`define BSCS_SIG_ADDR         24'h000000

// Retry count at which the flag toggles
`define BSCS_RETRY_LIMIT      7'd100

// Settling time in ms and system clock in kHz
`define BSCS_SETTLE_MS        200
`define BSCS_CLK_KHZ          250000

`endif

// file: logic/bscs_settle_timer.v
// Bandgap settling timer: counts a fixed number of cycles after start
`timescale 1ns/1ps
module bscs_settle_timer #(
  parameter [31:0] SETTLE_CYCLES = 32'd50000000  // Cycles to count
) (
  input  wire        clk_sys_i,  // System clock
  input  wire        rst_i,      // Sync reset, high
  input  wire        ce_i,       // Clock enable
  input  wire        start_i,    // Restart counting
  output reg         done_o      // Settling elapsed
);

  reg  [31:0] cnt_q;  // Elapsed cycles
  reg         run_q;  // Counting

  // Count up once started; done stays until next start
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= 32'h0;
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_i)
      begin
        cnt_q  <= 32'h1;
        run_q  <= 1'b1;
        done_o <= 1'b0;
      end
      else if (run_q)
      begin
        if (cnt_q >= SETTLE_CYCLES)
        begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 32'h1;
      end
    end
  end

endmodule // bscs_settle_timer

// file: logic/bscs_boot_sequencer.v
// Boot sequencer with system clock select and Avalon-MM register slave
// Contract
// - Status bit 2 mirrors clock-source select pin
// - Bit 0: 0 bypass, 1 PLL
// - Bypass uses pin-chosen clock; PLL uses generator
// - Boot starts automatically after every reset
// - Capture six boot pins into mode field
// - Fetch reset vector from ROM, PLL bypassed
// - Slew, idle, trim, clock-out disable, in order
// - Configure clock per mode, start settling timer
// - Main loop retries forever without valid signature
// - Serial flash: CS0, 24-bit, rate, port mode 1
// - Serial flash signature check, then config, load
// - Entry point at words 0x27FFA/0x27FFB
// - Reject dual-access entry or bad signatures
// - NOR: 16-bit signature check on CS2-5
// - NAND: 16-bit then 8-bit, fail if both
// - User code not before 200 ms settling
// - Toggle flag every 100 retries
// - Flag low after copy, then jump
`timescale 1ns/1ps
`include "bscs_consts.vh"
module bscs_boot_sequencer #(
  parameter [31:0] SETTLE_CYCLES = `BSCS_SETTLE_MS * `BSCS_CLK_KHZ,  // 200 ms at clock rate
  parameter [15:0] BOOT_SIG      = 16'h5a5a                         // Image signature word
) (
  input  wire        clk_sys_i,          // System clock, 250 MHz
  input  wire        rst_i,              // Sync reset, active high
  input  wire        ce_i,               // Clock enable, freezes all
  input  wire [15:0] avs_address_i,      // Avalon byte address
  input  wire        avs_read_i,         // Avalon read
  input  wire        avs_write_i,        // Avalon write
  input  wire [31:0] avs_writedata_i,    // Avalon write data
  output reg  [31:0] avs_readdata_o,     // Avalon read data
  output reg         avs_waitrequest_o,  // Avalon wait request
  input  wire [5:0]  boot_pins_i,        // Boot-select pins
  input  wire        clk_src_pin_i,      // Clock-source select pin
  output reg  [1:0]  sys_clk_src_o,      // Clock mux select
  output reg  [23:0] reset_vector_o,     // Reset fetch address
  output reg         clock_output_pin_slow_o,      // Clock output slow slew
  output reg         periph_idle_o,      // Idle peripherals, accelerator
  output reg         trim_apply_o,       // Bandgap trim strobe
  output reg         clock_output_pin_dis_o,       // Clock output disabled
  output reg         general_timer_zero_start_o,     // Settling timer start pulse
  output reg  [1:0]  sp1_mode_o,         // Serial port 1 mode
  output reg         sflash_fast_o,      // Serial flash 40 MHz rate
  output reg         rd_req_o,           // Read request
  output reg  [1:0]  rd_src_o,           // Read source
  output reg  [2:0]  rd_cs_o,            // Chip select
  output reg         rd_byte_o,          // 8-bit accesses
  output reg  [23:0] rd_addr_o,          // Read word address
  input  wire        rd_ack_i,           // Read done pulse
  input  wire [15:0] rd_data_i,          // Read data
  input  wire        host_int_i,         // Host-to-processor interrupt bit
  output reg         load_req_o,         // Config and image copy request
  input  wire        load_ack_i,         // Copy done pulse
  input  wire [31:0] load_entry_i,       // Entry from loaded image
  output reg         ext_flag_o,         // External flag output
  output reg         jump_o,             // Branch pulse
  output reg  [31:0] entry_o             // Branch target
);

  // Sequencer states
  localparam [3:0] ST_CAPT  = 4'h0;  // Capture pins
  localparam [3:0] ST_SLEW  = 4'h1;  // Slow slew
  localparam [3:0] ST_IDLE  = 4'h2;  // Idle peripherals
  localparam [3:0] ST_TRIM  = 4'h3;  // Bandgap trim
  localparam [3:0] ST_CKDIS = 4'h4;  // Clock out off
  localparam [3:0] ST_CLKC  = 4'h5;  // Clock setup, timer
  localparam [3:0] ST_LOOP  = 4'h6;  // Main loop head
  localparam [3:0] ST_RDRQ  = 4'h7;  // Issue read
  localparam [3:0] ST_RDWT  = 4'h8;  // Wait read
  localparam [3:0] ST_HPWT  = 4'h9;  // Wait host interrupt
  localparam [3:0] ST_LOAD  = 4'ha;  // Config and copy
  localparam [3:0] ST_SETL  = 4'hb;  // Wait settling
  localparam [3:0] ST_JUMP  = 4'hc;  // Branch issued
  localparam [3:0] ST_FAIL  = 4'hd;  // Retry bookkeeping

  reg  [3:0]  st_q;          // State
  reg  [5:0]  mode_q;        // Captured boot field
  reg         pll_sel_q;     // Clock select bit
  reg         pin_q;         // Sampled clock pin
  reg  [6:0]  retry_q;       // Retries since toggle
  reg  [1:0]  hp_idx_q;      // Host mailbox word
  reg  [15:0] hp_w0_q;       // Entry high
  reg  [15:0] hp_w1_q;       // Entry low
  reg  [15:0] hp_w2_q;       // Signature A
  reg         ack_q;         // Bus answer phase
  wire        settled;       // Settling elapsed
  wire [3:0]  mode = mode_q[3:0];  // Encoded source
  wire        sel_clk = (avs_address_i == (`BSCS_IDX_CLK_CFG << `BSCS_ADDR_SHIFT));
  wire        sel_mode = (avs_address_i == (`BSCS_IDX_BOOT_MODE << `BSCS_ADDR_SHIFT));

  // Clock mux code from select bit and pin
  function [1:0] clk_src_f;
    input sel;
    input pin;
    begin
      if (sel)
        clk_src_f = `BSCS_CLK_PLL;
      else
        clk_src_f = pin ? `BSCS_CLK_BYP_EXT : `BSCS_CLK_BYP_OSC;
    end
  endfunction

  // Clock select value the boot mode calls for
  function pll_for_mode_f;
    input [3:0] m;
    begin
      pll_for_mode_f = (m == `BSCS_MODE_HOSTPORT);
    end
  endfunction

  // Settling timer, started at clock setup
  bscs_settle_timer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) bscs_settle_timer_inst (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .start_i   (general_timer_zero_start_o),
    .done_o    (settled)
  );

  // Register slave: answer one cycle after request, write at taken edge
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ack_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      pin_q             <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_q <= clk_src_pin_i;
      if (!ack_q && (avs_read_i || avs_write_i))
      begin
        ack_q             <= 1'b1;
        avs_waitrequest_o <= 1'b0;
        // Reserved bits read zero; unmapped reads zero
        if (sel_clk)
          avs_readdata_o <= {29'h0, pin_q, 1'b0, pll_sel_q};
        else if (sel_mode)
          avs_readdata_o <= {26'h0, mode_q};
        else
          avs_readdata_o <= 32'h0;
      end
      else
      begin
        ack_q             <= 1'b0;
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // Boot sequence state machine; starts on its own after reset
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_q           <= ST_CAPT;
      mode_q         <= 6'h0;
      pll_sel_q      <= 1'b0;
      retry_q        <= 7'h0;
      hp_idx_q       <= 2'h0;
      hp_w0_q        <= 16'h0;
      hp_w1_q        <= 16'h0;
      hp_w2_q        <= 16'h0;
      sys_clk_src_o  <= `BSCS_CLK_BYP_OSC;
      reset_vector_o <= `BSCS_RESET_VECTOR;
      clock_output_pin_slow_o  <= 1'b0;
      periph_idle_o  <= 1'b0;
      trim_apply_o   <= 1'b0;
      clock_output_pin_dis_o   <= 1'b0;
      general_timer_zero_start_o <= 1'b0;
      sp1_mode_o     <= 2'h0;
      sflash_fast_o  <= 1'b0;
      rd_req_o       <= 1'b0;
      rd_src_o       <= `BSCS_SRC_SFLASH;
      rd_cs_o        <= `BSCS_CS_SFLASH;
      rd_byte_o      <= 1'b0;
      rd_addr_o      <= `BSCS_SIG_ADDR;
      load_req_o     <= 1'b0;
      ext_flag_o     <= 1'b1;
      jump_o         <= 1'b0;
      entry_o        <= 32'h0;
    end
    else if (ce_i)
    begin
      trim_apply_o   <= 1'b0;
      general_timer_zero_start_o <= 1'b0;
      jump_o         <= 1'b0;
      // Mux tracks select bit and sampled pin every cycle
      sys_clk_src_o <= clk_src_f(pll_sel_q, pin_q);
      // Software clock select; takes effect at the bus taken edge
      if (ack_q && avs_write_i && sel_clk)
        pll_sel_q <= avs_writedata_i[`BSCS_CCR_SYSSEL_BIT];
      case (st_q)
        ST_CAPT:
        begin
          // Only place the field is loaded, so it holds until reset
          mode_q <= boot_pins_i;
          st_q   <= ST_SLEW;
        end
        ST_SLEW:
        begin
          clock_output_pin_slow_o <= 1'b1;
          st_q          <= ST_IDLE;
        end
        ST_IDLE:
        begin
          periph_idle_o <= 1'b1;
          st_q          <= ST_TRIM;
        end
        ST_TRIM:
        begin
          trim_apply_o <= 1'b1;
          st_q         <= ST_CKDIS;
        end
        ST_CKDIS:
        begin
          clock_output_pin_dis_o <= 1'b1;
          st_q         <= ST_CLKC;
        end
        ST_CLKC:
        begin
          // Boot mode decides bypass or PLL; timer counts settling
          pll_sel_q      <= pll_for_mode_f(mode);
          general_timer_zero_start_o <= 1'b1;
          st_q           <= ST_LOOP;
        end
        ST_LOOP:
        begin
          // Head of main loop; every failed attempt comes back here
          rd_addr_o <= `BSCS_SIG_ADDR;
          rd_byte_o <= 1'b0;
          hp_idx_q  <= 2'h0;
          case (mode)
            `BSCS_MODE_SFLASH10, `BSCS_MODE_SFLASH40:
            begin
              sp1_mode_o    <= `BSCS_SP1_MODE_FLASH;
              sflash_fast_o <= (mode == `BSCS_MODE_SFLASH40);
              rd_src_o      <= `BSCS_SRC_SFLASH;
              rd_cs_o       <= `BSCS_CS_SFLASH;
              st_q          <= ST_RDRQ;
            end
            `BSCS_MODE_NOR, `BSCS_MODE_NAND:
            begin
              rd_src_o <= `BSCS_SRC_ASYNC;
              rd_cs_o  <= `BSCS_CS_FIRST_ASYNC;
              st_q     <= ST_RDRQ;
            end
            `BSCS_MODE_HOSTPORT:
            begin
              rd_src_o <= `BSCS_SRC_ONCHIP;
              rd_addr_o <= `BSCS_HP_ENTRY_HI;
              st_q     <= ST_HPWT;
            end
            default:
              st_q <= ST_FAIL;  // Sources outside this block never match
          endcase
        end
        ST_HPWT:
        begin
          // Host owns memory until it raises the interrupt bit
          if (host_int_i)
            st_q <= ST_RDRQ;
        end
        ST_RDRQ:
        begin
          rd_req_o <= 1'b1;
          st_q     <= ST_RDWT;
        end
        ST_RDWT:
        begin
          if (rd_ack_i)
          begin
            rd_req_o <= 1'b0;
            if (rd_src_o == `BSCS_SRC_ONCHIP)
            begin
              // Mailbox: entry high, entry low, signature A, signature B
              case (hp_idx_q)
                2'h0: hp_w0_q <= rd_data_i;
                2'h1: hp_w1_q <= rd_data_i;
                2'h2: hp_w2_q <= rd_data_i;
                default: hp_w2_q <= hp_w2_q;
              endcase
              if (hp_idx_q != `BSCS_HP_WORDS)
              begin
                hp_idx_q  <= hp_idx_q + 2'h1;
                rd_addr_o <= rd_addr_o + 24'h1;
                st_q      <= ST_RDRQ;
              end
              else if ((hp_w2_q == `BSCS_HP_SIG_A) && (rd_data_i == `BSCS_HP_SIG_B) &&
                       ({hp_w0_q, hp_w1_q} >= `BSCS_DUAL_ACCESS_RAM_END))
              begin
                entry_o    <= {hp_w0_q, hp_w1_q};
                ext_flag_o <= 1'b0;
                st_q       <= ST_SETL;
              end
              else
                st_q <= ST_FAIL;
            end
            else if (rd_data_i == BOOT_SIG)
            begin
              load_req_o <= 1'b1;
              st_q       <= ST_LOAD;
            end
            else if ((rd_src_o == `BSCS_SRC_ASYNC) && (rd_cs_o != `BSCS_CS_LAST_ASYNC))
            begin
              rd_cs_o <= rd_cs_o + 3'h1;
              st_q    <= ST_RDRQ;
            end
            else if ((rd_src_o == `BSCS_SRC_ASYNC) && (mode == `BSCS_MODE_NAND) && !rd_byte_o)
            begin
              // NAND second pass with byte accesses on every space
              rd_byte_o <= 1'b1;
              rd_cs_o   <= `BSCS_CS_FIRST_ASYNC;
              st_q      <= ST_RDRQ;
            end
            else
              st_q <= ST_FAIL;
          end
        end
        ST_LOAD:
        begin
          // Loader applies register section and copies image
          if (load_ack_i)
          begin
            load_req_o <= 1'b0;
            entry_o    <= load_entry_i;
            ext_flag_o <= 1'b0;
            st_q       <= ST_SETL;
          end
        end
        ST_SETL:
        begin
          if (settled)
          begin
            jump_o <= 1'b1;
            st_q   <= ST_JUMP;
          end
        end
        ST_JUMP:
          st_q <= ST_JUMP;  // Control now belongs to loaded code
        ST_FAIL:
        begin
          // Count the failure, toggle flag at the limit, retry same source
          if (retry_q == `BSCS_RETRY_LIMIT - 7'd1)
          begin
            retry_q    <= 7'h0;
            ext_flag_o <= ~ext_flag_o;
          end
          else
            retry_q <= retry_q + 7'h1;
          st_q <= ST_LOOP;
        end
        default:
          st_q <= ST_CAPT;
      endcase
    end
  end

endmodule // bscs_boot_sequencer

// file: testbench/bscs_boot_sequencer_assertions.sv
// Port-level checks for the boot sequencer
`timescale 1ns/1ps
module bscs_boot_checker #(
  parameter [31:0] SETTLE_CYCLES = 32'd20  // Settling span in cycles
) (
  input wire        clk_sys_i,          // Clock
  input wire        rst_i,              // Sync reset
  input wire [15:0] avs_address_i,      // Bus address
  input wire        avs_read_i,         // Bus read
  input wire        avs_write_i,        // Bus write
  input wire [31:0] avs_readdata_o,     // Bus read data
  input wire        avs_waitrequest_o,  // Bus wait
  input wire        clk_src_pin_i,      // Clock pin
  input wire [1:0]  sys_clk_src_o,      // Clock mux
  input wire [23:0] reset_vector_o,     // Fetch address
  input wire        clock_output_pin_slow_o,      // Slew step
  input wire        periph_idle_o,      // Idle step
  input wire        trim_apply_o,       // Trim step
  input wire        clock_output_pin_dis_o,       // Disable step
  input wire        general_timer_zero_start_o,     // Timer start
  input wire [1:0]  sp1_mode_o,         // Port mode
  input wire        rd_req_o,           // Read request
  input wire [1:0]  rd_src_o,           // Read source
  input wire [2:0]  rd_cs_o,            // Chip select
  input wire        rd_byte_o,          // Byte mode
  input wire [23:0] rd_addr_o,          // Read address
  input wire        rd_ack_i,           // Read answer
  input wire        load_req_o,         // Copy request
  input wire        load_ack_i,         // Copy done
  input wire        ext_flag_o,         // Flag
  input wire        jump_o              // Branch
);
  reg [31:0] since_q;  // Cycles since settling timer start

  // Saturating count so a long wait never wraps to zero
  always @(posedge clk_sys_i)
    if (rst_i || general_timer_zero_start_o)
      since_q <= 32'h0;
    else if (since_q != 32'hffffffff)
      since_q <= since_q + 32'h1;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Init steps, one per cycle, then clock setup
  sequence init_seq;
    $rose(periph_idle_o) ##1 trim_apply_o ##1 (clock_output_pin_dis_o && !trim_apply_o) ##1 general_timer_zero_start_o;
  endsequence

  init_order_a: assert property ($rose(clock_output_pin_slow_o) |=> init_seq)
    else $error("init steps out of order");
  trim_pulse_a: assert property (trim_apply_o |=> !trim_apply_o)
    else $error("trim strobe too long");
  bus_answer_a: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");
  cfg_read_a: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i == 16'h707c |->
    avs_readdata_o[31:3] == 29'h0 && !avs_readdata_o[1] && avs_readdata_o[2] == clk_src_pin_i
    && avs_readdata_o[0] == (sys_clk_src_o == 2'h2))
    else $error("clock config readback wrong");
  reset_vec_a: assert property (reset_vector_o == 24'hffff00)
    else $error("reset vector wrong");
  sflash_sel_a: assert property (rd_req_o && rd_src_o == 2'h0 |-> rd_cs_o == 3'h0 && sp1_mode_o == 2'h1)
    else $error("serial flash select wrong");
  async_cs_a: assert property (rd_req_o && rd_src_o == 2'h1 |-> rd_cs_o >= 3'h2 && rd_cs_o <= 3'h5)
    else $error("async chip select out of range");
  rd_hold_a: assert property (rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_addr_o) && $stable(rd_cs_o)
    && $stable(rd_byte_o))
    else $error("read request not held");
  rd_drop_a: assert property (rd_req_o && rd_ack_i |=> !rd_req_o)
    else $error("read request not released");
  flag_done_a: assert property (load_req_o && load_ack_i |-> ##[1:2] !ext_flag_o)
    else $error("flag not low after copy");
  settle_jump_a: assert property (jump_o |-> since_q >= SETTLE_CYCLES - 32'h1 && !ext_flag_o)
    else $error("branch before settling");
  jump_pulse_a: assert property (jump_o |=> !jump_o)
    else $error("branch pulse too long");
endmodule  // bscs_boot_checker

bind bscs_boot_sequencer bscs_boot_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) bscs_boot_checker_inst (.*);

// file: testbench/bscs_boot_partner.sv
// Boot memory and host memory model answering the read port
`timescale 1ns/1ps
module bscs_boot_partner #(
  parameter [15:0] SIG   = 16'h5a5a,     // Valid image signature
  parameter [31:0] ENTRY = 32'h00012345  // Entry of a copied image
) (
  input  wire        clk_sys_i,             // System clock
  input  wire        rd_req_i,              // Read request
  input  wire [1:0]  rd_src_i,              // Read source
  input  wire [2:0]  rd_cs_i,               // Chip select
  input  wire        rd_byte_i,             // 8-bit accesses
  input  wire [23:0] rd_addr_i,             // Word address
  input  wire        load_req_i,            // Copy request
  input  wire [2:0]  match_cs_i,            // Space holding the image
  input  wire        match_byte_i,          // Image is 8-bit wide
  input  wire [2:0]  slow_i,                // Wait cycles per read
  input  wire        host_bad_i,            // Host wrote a bad signature
  input  wire [31:0] host_entry_i,          // Entry written by host
  output reg         rd_ack_o = 1'b0,       // Read answer
  output reg  [15:0] rd_data_o = 16'h0000,  // Read data
  output reg         load_ack_o = 1'b0,     // Copy done
  output wire [31:0] load_entry_o           // Copied entry
);
  reg [2:0]  wait_q = 3'h0;  // Cycles waited on this read
  reg [15:0] word;           // Content at the requested place

  assign load_entry_o = ENTRY;

  // Async spaces read as a flash already put back in read mode by its 0xf0 reset
  // Only the chosen space and width hold a valid signature
  always @*
  begin
    if (rd_src_i != 2'h2)
      word = (rd_cs_i == match_cs_i && rd_byte_i == match_byte_i) ? SIG : ~SIG;
    else if (rd_addr_i[1:0] == 2'h2)
      word = host_entry_i[31:16];
    else if (rd_addr_i[1:0] == 2'h3)
      word = host_entry_i[15:0];
    else if (rd_addr_i[1:0] == 2'h0)
      word = host_bad_i ? 16'h1235 : 16'h1234;
    else
      word = 16'habcd;
  end

  // Answer after a delay; data invert on cycles with no request and no answer, so stale words hold still only while a read waits or is answered
  always @(posedge clk_sys_i)
  begin
    rd_ack_o <= 1'b0;
    load_ack_o <= load_req_i && !load_ack_o;
    if (rd_req_i && !rd_ack_o)
    begin
      if (wait_q >= slow_i)
      begin
        rd_ack_o <= 1'b1;
        rd_data_o <= word;
        wait_q <= 3'h0;
      end
      else
        wait_q <= wait_q + 3'h1;
    end
    else if (!rd_ack_o)
      rd_data_o <= ~rd_data_o;
  end
endmodule  // bscs_boot_partner

// file: testbench/boot_sequencer_clock_select_bench.sv
// Self-checking bench for the boot sequencer and clock select
`timescale 1ns/1ps
module boot_sequencer_clock_select_bench;
  reg         clk_sys_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;      // Clock, reset, enable
  reg  [15:0] avs_address_i = 16'h0000;                         // Bus address
  reg         avs_read_i = 1'b0, avs_write_i = 1'b0;            // Bus strobes
  reg  [31:0] avs_writedata_i = 32'h0, host_entry = 32'h30000;  // Write data, host entry
  reg  [5:0]  boot_pins_i = 6'h00;                              // Boot pins
  reg         clk_src_pin_i = 1'b0, host_int_i = 1'b0;          // Clock pin, host interrupt
  reg  [2:0]  match_cs = 3'h4, slow = 3'h1;                     // Image space, answer delay
  reg         match_byte = 1'b0, host_bad = 1'b1;               // Image width, bad signature
  wire [31:0] avs_readdata_o, load_entry_i, entry_o;
  wire [23:0] reset_vector_o, rd_addr_o;
  wire [15:0] rd_data_i;
  wire [2:0]  rd_cs_o;
  wire [1:0]  sys_clk_src_o, sp1_mode_o, rd_src_o;
  wire        avs_waitrequest_o, clock_output_pin_slow_o, periph_idle_o, trim_apply_o, clock_output_pin_dis_o, general_timer_zero_start_o;
  wire        sflash_fast_o, rd_req_o, rd_byte_o, rd_ack_i, load_req_o, load_ack_i, ext_flag_o, jump_o;
  integer     err_total = 0, checks = 0, i;  // Counters, loop index
  reg  [31:0] q;                             // Last read data
  reg  [3:0]  log_q[$];                      // {byte mode, cs} of answered reads

  always #2 clk_sys_i = ~clk_sys_i;

  bscs_boot_sequencer #(.SETTLE_CYCLES(32'd20), .BOOT_SIG(16'h5a5a)) bscs_boot_sequencer_inst (.*);
  bscs_boot_partner bscs_boot_partner_inst (.clk_sys_i(clk_sys_i), .rd_req_i(rd_req_o), .rd_src_i(rd_src_o),
    .rd_cs_i(rd_cs_o), .rd_byte_i(rd_byte_o), .rd_addr_i(rd_addr_o), .load_req_i(load_req_o),
    .match_cs_i(match_cs), .match_byte_i(match_byte), .slow_i(slow), .host_bad_i(host_bad),
    .host_entry_i(host_entry), .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i), .load_ack_o(load_ack_i),
    .load_entry_o(load_entry_i));

  // Log each answered read to check source order
  always @(posedge clk_sys_i)
    if (rd_req_o && rd_ack_i)
      log_q.push_back({rd_byte_o, rd_cs_o});

  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask

  // One bus transfer held until waitrequest is sampled low
  task bus(input rd, input [15:0] a, input [31:0] wd);
    integer n;
  begin
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20)
    begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
    chk("waitrequest", 0, avs_waitrequest_o);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  end
  endtask

  task boot(input [5:0] p);
  begin
    boot_pins_i <= p;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    log_q.delete();
  end
  endtask

  task wjump(input integer lim);
    integer n;
  begin
    n = 0;
    while (jump_o !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
  end
  endtask

  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // Main sequence: NOR boot, registers, NAND, serial flash, retries, host port
  initial
  begin
    clk_src_pin_i <= 1'b1;
    boot(6'h30);
    chk("vector", 24'hffff00, reset_vector_o);
    wjump(2000);
    chk("nor jump", 1, jump_o);
    chk("entry", 32'h00012345, entry_o);
    chk("reads", 3, log_q.size());
    chk("last cs", 4'h4, log_q[2]);
    bus(0, 16'h70d0, 32'hffffffff);
    bus(1, 16'h0000, 0);
    chk("unmapped", 0, q);
    boot_pins_i <= 6'h0f;
    bus(1, 16'h70d0, 0);
    chk("mode", 32'h30, q);
    for (i = 0; i < 2; i = i + 1)
    begin
      clk_src_pin_i <= i[0];
      bus(0, 16'h707c, 32'h0);
      bus(1, 16'h707c, 0);
      chk("cfg", {29'h0, i[0], 2'b00}, q);
      chk("mux", {1'b0, i[0]}, sys_clk_src_o);
      bus(0, 16'h707c, 32'h1);
      bus(1, 16'h707c, 0);
      chk("cfg pll", {29'h0, i[0], 2'b01}, q);
      chk("mux pll", 2'h2, sys_clk_src_o);
    end
    match_cs <= 3'h5;
    match_byte <= 1'b1;
    boot(6'h01);
    wjump(2000);
    chk("reads", 8, log_q.size());
    chk("wide last", 4'h5, log_q[3]);
    chk("byte last", 4'hd, log_q[7]);
    match_cs <= 3'h0;
    match_byte <= 1'b0;
    for (i = 13; i < 15; i = i + 1)
    begin
      boot(i[5:0]);
      wjump(2000);
      chk("sf jump", 1, jump_o);
      chk("sf cs", 4'h0, log_q[0]);
      chk("sf rate", i - 13, sflash_fast_o);
    end
    match_cs <= 3'h7;
    slow <= 3'h2;
    boot(6'h00);
    i = 0;
    while (ext_flag_o !== 1'b0 && i < 5000)
    begin
      @(posedge clk_sys_i);
      i = i + 1;
    end
    chk("flag toggle", 0, ext_flag_o);
    chk("fail reads", 400, log_q.size());
    for (i = 0; i < 400; i = i + 1)
      chk("retry cs", i % 4 + 2, log_q[i]);
    match_cs <= 3'h2;
    wjump(2000);
    chk("late jump", 1, jump_o);
    boot(6'h0c);
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk("frozen", 0, clock_output_pin_slow_o);
    ce_i <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    chk("host pll", 2'h2, sys_clk_src_o);
    for (i = 0; i < 3; i = i + 1)
    begin
      host_int_i <= 1'b1;
      @(posedge clk_sys_i);
      host_int_i <= 1'b0;
      wjump(200);
      chk("host jump", i == 2, jump_o);
      host_bad <= 1'b0;
      host_entry <= (i == 0) ? 32'h00007ffe : 32'h00030000;
    end
    chk("host entry", 32'h00030000, entry_o);
    tally_and_finish;
  end

  // Watchdog well past the expected run length
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    err_total = err_total + 1;
    $display("wrong value run length expected done seen hang");
    tally_and_finish;
  end
endmodule  // boot_sequencer_clock_select_bench
